// *** hdl/buck_supervisor_pkg.sv ***
// Constants and types shared by the octal buck supervisor.
package buck_supervisor_pkg;

  localparam int NCH           = 8;
  localparam int GROUP_MAX     = 4;
  localparam int PAIR_W        = 2;

  // Times in ns and in 40 ns clock cycles.
  localparam int CLK_PERIOD_NS  = 40;
  localparam int EN_DELAY_NS    = 100000;
  localparam int FIRST_EXTRA_NS = 1500000;
  localparam int FILTER_NS      = 100000;
  localparam int SYNC_LOSS_NS   = 5000;
  localparam int EN_DELAY_CYC    = (EN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRST_EXTRA_CYC = (FIRST_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CYC      = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LOSS_CYC   = (SYNC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W  = 17;
  localparam int FLT_W  = 12;
  localparam int GAP_W  = 8;
  localparam int FREQ_W = 16;
  localparam int ACC_W  = 18;
  localparam int QCNT_W = 4;
  localparam int ADDR_W = 8;

  // Oscillator, in kHz.
  localparam logic [FREQ_W-1:0] FREQ_MIN_KHZ     = 16'h00fa;
  localparam logic [FREQ_W-1:0] FREQ_MAX_KHZ     = 16'h0fa0;
  localparam logic [FREQ_W-1:0] FREQ_DEFAULT_KHZ = 16'h07d0;
  localparam logic [FREQ_W-1:0] FREQ_STEP_KHZ    = 16'h0004;
  localparam logic [ACC_W-1:0]  CLK_KHZ          = 18'h061a8;
  localparam logic [QCNT_W-1:0] QUARTERS         = 4'h4;

  // Register map.
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] GROUP_OFFSET  = 8'h08;
  localparam logic [ADDR_W-1:0] OSC_OFFSET    = 8'h0c;
  localparam logic [FREQ_W-1:0] CTRL_RESET    = 16'h07d0;
  localparam int ST_OK_LSB      = 0;
  localparam int ST_RUN_LSB     = 8;
  localparam int ST_SUMMARY_BIT = 16;
  localparam int ST_THERMAL_BIT = 17;
  localparam int ST_SYNC_BIT    = 18;
  localparam int ST_FCM_BIT     = 19;
  localparam int ST_PRECISE_BIT = 20;
  localparam int GR_MASTER_LSB  = 0;
  localparam int GR_SLAVE_LSB   = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    CH_OFF  = 2'b00,
    CH_WAIT = 2'b01,
    CH_RUN  = 2'b10
  } chan_state_t;

endpackage : buck_supervisor_pkg

// *** hdl/octal_buck_supervisor.sv ***
// Supervisor and sequencer for an eight-channel buck regulator.
// Operation
// R1 - Mode input picks light-load skipping when low, forced continuous when high.
// R2 - Enable threshold is 730mV with all channels off, 400mV once any runs; precise_threshold rises once any channel is enabled.
// R3 - Switching starts 100us after enable, plus 1.5ms for the first channel.
// R4 - High-side turn-on phases are 0, 90, 180, 270 degrees per channel pair.
// R5 - Phase nodes of shut-down channels are not driven at all.
// R6 - Up to four adjacent channels merge; sense tied to supply marks a slave.
// R7 - Only the master enable controls a group; slave enables are held low.
// R8 - Channel one is never a slave and channel eight never a master.
// R9 - Channel ok rises above 98% for channel one, 95% for the others.
// R10 - Channel ok falls below 97% for channel one, 94% for the others.
// R11 - Summary pulls low after a channel ok stays low over 100us.
// R12 - A rising channel ok reaches the summary after 100us.
// R13 - Excess output pulls summary low after 100us, releases 100us after clearing.
// R14 - Summary faults are not latched and release once no fault remains.
// R15 - Summary is low with no channel on, any lockout, or thermal shutdown; channel lockouts count only where en_eff is set.
// R16 - Shutdown at 170C holds channels off until 160C.
// R17 - Temperature monitor is off with no channel enabled or output tied to bias.
// R18 - Oscillator is clamped to 250kHz..4MHz; tied frequency input selects 2MHz.
// R19 - Pair one turns on at each sync rising edge.
// R20 - A present sync clock forces continuous mode.
// R21 - Sync loss found after 5us, then frequency glides back.
// R22 - Sync is 1MHz..3MHz from outside, or held at ground.
// R23 - Summary output is open drain: only pulled low, pull-up gives high.
// R24 - Delays and filters are counters of the clock.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module octal_buck_supervisor #(
  parameter int FIRST_EXTRA_CYC = buck_supervisor_pkg::FIRST_EXTRA_CYC
) (
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  input  wire logic                                   clk_en,
  input  wire logic                                   mode_pin,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    channel_enable,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    output_sense_at_supply,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    above_rise,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    above_hold,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    above_excess,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    above_excess_clear,
  input  wire logic [buck_supervisor_pkg::NCH-1:0]    channel_low_supply_lockout,
  input  wire logic                                   bias_low_supply_lockout,
  input  wire logic                                   temp_hot,
  input  wire logic                                   temp_cool,
  input  wire logic                                   temp_out_tied_bias,
  input  wire logic                                   freq_set_resistor_tied_bias,
  input  wire logic                                   sync_in,
  output logic                                        summary_ok_out,
  output logic                                        summary_ok_oe,
  output logic [buck_supervisor_pkg::NCH-1:0]         phase_node_drive,
  output logic [buck_supervisor_pkg::NCH-1:0]         phase_node_hs_on,
  output logic [buck_supervisor_pkg::NCH-1:0]         channel_ok,
  output logic [buck_supervisor_pkg::NCH-1:0]         excess_output_flag,
  output logic                                        forced_continuous,
  output logic                                        precise_threshold,
  output logic                                        temp_monitor_on,
  output logic                                        thermal_shutdown,
  input  wire logic [buck_supervisor_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [31:0]                            s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  input  wire logic [buck_supervisor_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [31:0]                                 s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready
);

  localparam int NCH = buck_supervisor_pkg::NCH;

  typedef logic [buck_supervisor_pkg::CNT_W-1:0]  dly_t;
  typedef logic [buck_supervisor_pkg::FLT_W-1:0]  flt_t;
  typedef logic [buck_supervisor_pkg::GAP_W-1:0]  gap_t;
  typedef logic [buck_supervisor_pkg::FREQ_W-1:0] freq_t;
  typedef logic [buck_supervisor_pkg::ACC_W-1:0]  acc_t;
  typedef logic [buck_supervisor_pkg::QCNT_W-1:0] qcnt_t;
  typedef logic [buck_supervisor_pkg::PAIR_W-1:0] pair_t;
  typedef logic [buck_supervisor_pkg::ADDR_W-1:0] addr_t;

  typedef struct packed {
    buck_supervisor_pkg::chan_state_t [NCH-1:0] ch;
    dly_t [NCH-1:0]                             dly;
    logic [NCH-1:0]                             ok;
    logic [NCH-1:0]                             filt_ok;
    flt_t [NCH-1:0]                             flt;
    logic [NCH-1:0]                             excess;
    logic                                       excess_filt;
    flt_t                                       excess_cnt;
    logic                                       thermal;
    logic                                       summary_low;
    logic                                       fcm;
    logic                                       precise;
    logic                                       temp_on;
    logic                                       sync_prev;
    logic                                       sync_present;
    gap_t                                       sync_gap;
    acc_t                                       acc;
    pair_t                                      quarter;
    qcnt_t                                      qcount;
    freq_t                                      cur_f;
    logic [NCH-1:0]                             hs_on;
    freq_t                                      freq_reg;
    logic                                       aw_held;
    logic                                       w_held;
    addr_t                                      awaddr;
    logic [31:0]                                wdata;
    logic [3:0]                                 wstrb;
    logic                                       bvalid;
    logic [1:0]                                 bresp;
    logic                                       rvalid;
    logic [31:0]                                rdata;
    logic [1:0]                                 rresp;
  } state_t;

  state_t         s;
  state_t         next_s;
  logic [NCH-1:0] slave;
  logic [NCH-1:0] master;
  logic [NCH-1:0] en_eff;
  logic [NCH-1:0] watched;
  freq_t          target_f;

  // Group decode is pure wiring of the straps; a run longer than four starts a new group.
  always_comb begin
    int run_len;
    run_len = 0;
    slave = '0;
    master = '0;
    for (int i = 1; i < NCH; i++) begin
      if (output_sense_at_supply[i] && run_len < buck_supervisor_pkg::GROUP_MAX - 1) begin // R6 R8
        slave[i] = 1'b1;
        run_len = run_len + 1;
      end else begin
        run_len = 0;
      end
    end
    for (int i = 0; i < NCH - 1; i++) begin
      master[i] = !slave[i] && slave[i + 1]; // R8
    end
    en_eff[0] = channel_enable[0];
    for (int i = 1; i < NCH; i++) begin
      en_eff[i] = slave[i] ? en_eff[i - 1] : channel_enable[i]; // R7
    end
    watched = en_eff & ~slave;
  end

  always_comb begin
    if (freq_set_resistor_tied_bias) begin
      target_f = buck_supervisor_pkg::FREQ_DEFAULT_KHZ; // R18
    end else if (s.freq_reg < buck_supervisor_pkg::FREQ_MIN_KHZ) begin
      target_f = buck_supervisor_pkg::FREQ_MIN_KHZ; // R18
    end else if (s.freq_reg > buck_supervisor_pkg::FREQ_MAX_KHZ) begin
      target_f = buck_supervisor_pkg::FREQ_MAX_KHZ; // R18
    end else begin
      target_f = s.freq_reg;
    end
  end

  always_comb begin
    logic  first;
    logic  stop;
    logic  sync_rise;
    acc_t  nco_sum;
    pair_t q_next;
    logic  q_tick;
    addr_t ra;
    next_s = s;
    first = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (s.ch[i] != buck_supervisor_pkg::CH_OFF) begin
        first = 1'b0;
      end
    end

    // Channel sequencing; thermal shutdown and lockouts force channels off.
    for (int i = 0; i < NCH; i++) begin
      stop = !en_eff[i] || s.thermal || channel_low_supply_lockout[i]
             || bias_low_supply_lockout; // R16
      unique case (s.ch[i])
        buck_supervisor_pkg::CH_OFF: begin
          if (!stop) begin
            next_s.ch[i] = buck_supervisor_pkg::CH_WAIT;
            next_s.dly[i] = dly_t'(buck_supervisor_pkg::EN_DELAY_CYC - 1
                            + (first ? FIRST_EXTRA_CYC : 0)); // R3 R24
          end
        end
        buck_supervisor_pkg::CH_WAIT: begin
          if (stop) begin
            next_s.ch[i] = buck_supervisor_pkg::CH_OFF;
          end else if (s.dly[i] == '0) begin
            next_s.ch[i] = buck_supervisor_pkg::CH_RUN; // R3
          end else begin
            next_s.dly[i] = s.dly[i] - dly_t'(1);
          end
        end
        buck_supervisor_pkg::CH_RUN: begin
          if (stop) begin
            next_s.ch[i] = buck_supervisor_pkg::CH_OFF;
          end
        end
        default: begin
          next_s.ch[i] = buck_supervisor_pkg::CH_OFF;
        end
      endcase

      // Channel ok with hysteresis; comparators set the percentages.
      if (s.ch[i] != buck_supervisor_pkg::CH_RUN || slave[i]) begin
        next_s.ok[i] = 1'b0;
      end else if (!s.ok[i] && above_rise[i]) begin
        next_s.ok[i] = 1'b1; // R9
      end else if (s.ok[i] && !above_hold[i]) begin
        next_s.ok[i] = 1'b0; // R10
      end

      // A change of channel ok must persist before the summary sees it.
      if (!watched[i] || s.ok[i] == s.filt_ok[i]) begin
        next_s.flt[i] = '0;
        if (!watched[i]) begin
          next_s.filt_ok[i] = 1'b0;
        end
      end else if (s.ok[i] && s.flt[i] == flt_t'(buck_supervisor_pkg::FILTER_CYC - 1)) begin
        next_s.filt_ok[i] = 1'b1; // R12
        next_s.flt[i] = '0;
      end else if (!s.ok[i] && s.flt[i] == flt_t'(buck_supervisor_pkg::FILTER_CYC)) begin
        next_s.filt_ok[i] = 1'b0; // R11
        next_s.flt[i] = '0;
      end else begin
        next_s.flt[i] = s.flt[i] + flt_t'(1);
      end

      if (s.ch[i] != buck_supervisor_pkg::CH_RUN || slave[i]) begin
        next_s.excess[i] = 1'b0;
      end else if (above_excess[i]) begin
        next_s.excess[i] = 1'b1; // R13
      end else if (!above_excess_clear[i]) begin
        next_s.excess[i] = 1'b0; // R13
      end
    end

    // Excess output is filtered 100us in both directions.
    if ((|s.excess) == s.excess_filt) begin
      next_s.excess_cnt = '0;
    end else if (s.excess_cnt == flt_t'(buck_supervisor_pkg::FILTER_CYC - 1)) begin
      next_s.excess_filt = |s.excess; // R13
      next_s.excess_cnt = '0;
    end else begin
      next_s.excess_cnt = s.excess_cnt + flt_t'(1);
    end

    // Setting wins over clearing if both comparators fire together.
    if (temp_hot) begin
      next_s.thermal = 1'b1; // R16
    end else if (temp_cool) begin
      next_s.thermal = 1'b0; // R16
    end

    // Recomputed each cycle, so nothing latches.
    next_s.summary_low = !(|en_eff) || |(en_eff & channel_low_supply_lockout)
                         || bias_low_supply_lockout || s.thermal || s.excess_filt
                         || |(watched & ~s.filt_ok); // R14 R15
    next_s.precise = |en_eff; // R2
    next_s.temp_on = (|en_eff) && !temp_out_tied_bias; // R17
    next_s.fcm = mode_pin || s.sync_present; // R1 R20

    // Sync is gone after 5us without a rising edge.
    sync_rise = sync_in && !s.sync_prev;
    next_s.sync_prev = sync_in;
    if (sync_rise) begin
      next_s.sync_present = 1'b1;
      next_s.sync_gap = '0;
    end else if (s.sync_gap == gap_t'(buck_supervisor_pkg::SYNC_LOSS_CYC)) begin
      next_s.sync_present = 1'b0; // R21
    end else begin
      next_s.sync_gap = s.sync_gap + gap_t'(1);
    end

    // The accumulator runs on while loss is pending.
    nco_sum = s.acc + acc_t'({s.cur_f, 2'b00});
    q_tick = nco_sum >= buck_supervisor_pkg::CLK_KHZ;
    q_next = s.quarter;
    next_s.hs_on = '0;
    if (sync_rise) begin
      next_s.acc = '0;
      q_next = '0; // R19
      next_s.qcount = '0;
      if (s.sync_present) begin
        // A bang-bang step walks the frequency toward the sync rate.
        if (s.qcount < buck_supervisor_pkg::QUARTERS
            && s.cur_f < buck_supervisor_pkg::FREQ_MAX_KHZ) begin
          next_s.cur_f = s.cur_f + buck_supervisor_pkg::FREQ_STEP_KHZ; // R21
        end else if (s.qcount > buck_supervisor_pkg::QUARTERS
                     && s.cur_f > buck_supervisor_pkg::FREQ_MIN_KHZ) begin
          next_s.cur_f = s.cur_f - buck_supervisor_pkg::FREQ_STEP_KHZ; // R21
        end
      end
    end else if (q_tick) begin
      next_s.acc = nco_sum - buck_supervisor_pkg::CLK_KHZ; // R24
      q_next = s.quarter + pair_t'(1);
      if (s.qcount != '1) begin
        next_s.qcount = s.qcount + qcnt_t'(1);
      end
      if (!s.sync_present) begin
        if (s.cur_f + buck_supervisor_pkg::FREQ_STEP_KHZ < target_f) begin
          next_s.cur_f = s.cur_f + buck_supervisor_pkg::FREQ_STEP_KHZ; // R21
        end else if (s.cur_f > target_f + buck_supervisor_pkg::FREQ_STEP_KHZ) begin
          next_s.cur_f = s.cur_f - buck_supervisor_pkg::FREQ_STEP_KHZ; // R21
        end else begin
          next_s.cur_f = target_f; // R18
        end
      end
    end else begin
      next_s.acc = nco_sum;
    end
    next_s.quarter = q_next;
    if (sync_rise || q_tick) begin
      for (int i = 0; i < NCH; i++) begin
        next_s.hs_on[i] = (pair_t'(i / 2) == q_next)
                          && s.ch[i] == buck_supervisor_pkg::CH_RUN; // R4 R19
      end
    end

    // AXI4-Lite write: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = buck_supervisor_pkg::RESP_OKAY;
      if (s.awaddr[7:2] == buck_supervisor_pkg::CTRL_OFFSET[7:2]) begin
        for (int b = 0; b < 2; b++) begin
          if (s.wstrb[b]) begin
            next_s.freq_reg[b * 8 +: 8] = s.wdata[b * 8 +: 8];
          end
        end
      end else if (s.awaddr[7:2] != buck_supervisor_pkg::STATUS_OFFSET[7:2]
                   && s.awaddr[7:2] != buck_supervisor_pkg::GROUP_OFFSET[7:2]
                   && s.awaddr[7:2] != buck_supervisor_pkg::OSC_OFFSET[7:2]) begin
        next_s.bresp = buck_supervisor_pkg::RESP_DECERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // AXI4-Lite read.
    ra = s_axi_araddr;
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = '0;
      next_s.rresp = buck_supervisor_pkg::RESP_OKAY;
      if (ra[7:2] == buck_supervisor_pkg::CTRL_OFFSET[7:2]) begin
        next_s.rdata[buck_supervisor_pkg::FREQ_W-1:0] = s.freq_reg;
      end else if (ra[7:2] == buck_supervisor_pkg::STATUS_OFFSET[7:2]) begin
        next_s.rdata[buck_supervisor_pkg::ST_OK_LSB +: NCH] = s.ok;
        for (int i = 0; i < NCH; i++) begin
          next_s.rdata[buck_supervisor_pkg::ST_RUN_LSB + i] =
            s.ch[i] == buck_supervisor_pkg::CH_RUN;
        end
        next_s.rdata[buck_supervisor_pkg::ST_SUMMARY_BIT] = !s.summary_low;
        next_s.rdata[buck_supervisor_pkg::ST_THERMAL_BIT] = s.thermal;
        next_s.rdata[buck_supervisor_pkg::ST_SYNC_BIT] = s.sync_present;
        next_s.rdata[buck_supervisor_pkg::ST_FCM_BIT] = s.fcm;
        next_s.rdata[buck_supervisor_pkg::ST_PRECISE_BIT] = s.precise;
      end else if (ra[7:2] == buck_supervisor_pkg::GROUP_OFFSET[7:2]) begin
        next_s.rdata[buck_supervisor_pkg::GR_MASTER_LSB +: NCH] = master;
        next_s.rdata[buck_supervisor_pkg::GR_SLAVE_LSB +: NCH] = slave;
      end else if (ra[7:2] == buck_supervisor_pkg::OSC_OFFSET[7:2]) begin
        next_s.rdata[buck_supervisor_pkg::FREQ_W-1:0] = s.cur_f;
      end else begin
        next_s.rresp = buck_supervisor_pkg::RESP_DECERR;
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.summary_low <= 1'b1; // R15
      s.freq_reg <= buck_supervisor_pkg::CTRL_RESET;
      s.cur_f <= buck_supervisor_pkg::FREQ_DEFAULT_KHZ;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Open drain: the pin is only ever pulled low.
  assign summary_ok_out = 1'b0; // R23
  assign summary_ok_oe = s.summary_low; // R23
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      phase_node_drive[i] = s.ch[i] == buck_supervisor_pkg::CH_RUN; // R5
    end
  end
  assign phase_node_hs_on = s.hs_on;
  assign channel_ok = s.ok;
  assign excess_output_flag = s.excess;
  assign forced_continuous = s.fcm;
  assign precise_threshold = s.precise;
  assign temp_monitor_on = s.temp_on;
  assign thermal_shutdown = s.thermal;
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

endmodule : octal_buck_supervisor

// *** dv/buck_sup_properties.sv ***
// Port checks for the supervisor.
`timescale 1ns/1ps
module buck_sup_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       mode_pin,
  input wire logic [7:0] channel_enable,
  input wire logic       bias_low_supply_lockout,
  input wire logic       temp_out_tied_bias,
  input wire logic       summary_ok_out,
  input wire logic       summary_ok_oe,
  input wire logic [7:0] phase_node_drive,
  input wire logic [7:0] phase_node_hs_on,
  input wire logic [7:0] channel_ok,
  input wire logic       forced_continuous,
  input wire logic       precise_threshold,
  input wire logic       temp_monitor_on,
  input wire logic       thermal_shutdown
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  out_low_a: assert property (summary_ok_out == 1'b0) else $error("summary data high");
  mode_fcm_a: assert property (mode_pin |=> forced_continuous) else $error("mode lost");
  pair_sep_a: assert property (|phase_node_hs_on[1:0] |-> !(|phase_node_hs_on[7:2]))
    else $error("phase overlap");
  therm_off_a: assert property (thermal_shutdown[*2] |-> phase_node_drive == 8'h00)
    else $error("runs while hot");
  idle_low_a: assert property ((channel_enable == 8'h00 || bias_low_supply_lockout
    || thermal_shutdown)[*2] |=> summary_ok_oe) else $error("summary released");
  thr_low_a: assert property ((channel_enable == 8'h00)[*3] |-> !precise_threshold)
    else $error("threshold");
  mon_off_a: assert property ((temp_out_tied_bias || channel_enable == 8'h00)[*3]
    |-> !temp_monitor_on) else $error("monitor on");
  ok_delay_a: assert property ($fell(summary_ok_oe) |-> $past(channel_ok, 8) != 8'h00)
    else $error("early release");
  cover property ($rose(|phase_node_drive));
  cover property ($fell(summary_ok_oe));
  cover property ($rose(thermal_shutdown));
endmodule : buck_sup_properties
bind octal_buck_supervisor buck_sup_properties chk_u (.*);

// *** dv/host_monitor.sv ***
// Processor side of the summary line.
`timescale 1ns/1ps
module host_monitor (
  input  wire logic summary_ok_oe,
  output logic      summary_ok_line
);
  // The pull-up alone gives the ok level.
  assign summary_ok_line = summary_ok_oe ? 1'b0 : 1'b1;
endmodule : host_monitor

// *** dv/tb_octal_buck_supervisor.sv ***
// Bench for the octal buck supervisor.
`timescale 1ns/1ps
module tb_octal_buck_supervisor;
  logic aclk, aresetn, clk_en, mode_pin, bias_low_supply_lockout, temp_hot, temp_cool, pg;
  logic temp_out_tied_bias, freq_set_resistor_tied_bias, sync_in, summary_ok_out, summary_ok_oe;
  logic forced_continuous, precise_threshold, temp_monitor_on, thermal_shutdown;
  logic [7:0] channel_enable, output_sense_at_supply, above_rise, above_hold, above_excess;
  logic [7:0] above_excess_clear, channel_low_supply_lockout, phase_node_drive, phase_node_hs_on;
  logic [7:0] channel_ok, excess_output_flag, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ga, gw;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int n_errors, tests_run, n;
  octal_buck_supervisor #(.FIRST_EXTRA_CYC(20)) dut_u (.*);
  host_monitor mon_u (.summary_ok_oe, .summary_ok_line(pg));
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    {ga, gw} = 2'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    while (ga || gw) begin
      @(posedge aclk);
      {ga, gw} = {ga && !s_axi_awready, gw && !s_axi_wready};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ga, gw, !(ga || gw)};
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask : axw
  task axr(input logic [7:0] a);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(posedge aclk); while (!s_axi_arready);
    {s_axi_arvalid, s_axi_rready} <= 2'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axr
  task t_seq;
    chk({summary_ok_oe, pg, phase_node_drive, precise_threshold}, 11'h400);
    mode_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(forced_continuous, 1'b1);
    {mode_pin, above_rise, above_hold, channel_enable} <= {1'b0, 24'hffff01};
    n = 0;
    while (!phase_node_drive[0] && n < 5000) begin @(posedge aclk); n++; end
    chk(n > 2518 && n < 2526, 1'b1);
    chk({precise_threshold, forced_continuous}, 2'h2);
    channel_enable <= 8'h03;
    n = 0;
    while (!phase_node_drive[1] && n < 5000) begin @(posedge aclk); n++; end
    chk(n > 2498 && n < 2506, 1'b1);
  endtask : t_seq
  task t_sum;
    n = 0;
    while (summary_ok_oe && n < 5000) begin @(posedge aclk); n++; end
    chk({n > 2400, pg}, 2'h3);
    {above_rise, above_hold} <= 16'hfefe;
    repeat (100) @(posedge aclk);
    chk(summary_ok_oe, 1'b0);
    {above_rise, above_hold, above_excess, above_excess_clear} <= 32'hffff0101;
    repeat (2400) @(posedge aclk);
    chk({summary_ok_oe, excess_output_flag}, 9'h001);
    repeat (200) @(posedge aclk);
    chk(summary_ok_oe, 1'b1);
    {above_excess, above_excess_clear} <= 16'h0;
    repeat (2700) @(posedge aclk);
    chk(summary_ok_oe, 1'b0);
  endtask : t_sum
  task t_stop;
    temp_hot <= 1'b1;
    repeat (4) @(posedge aclk);
    {temp_hot, bias_low_supply_lockout} <= 2'h1;
    repeat (4) @(posedge aclk);
    chk({phase_node_drive, summary_ok_oe}, 9'h001);
    {temp_cool, bias_low_supply_lockout} <= 2'h2;
    repeat (3000) @(posedge aclk);
    chk(phase_node_drive[1:0], 2'h3);
    temp_cool <= 1'b0;
  endtask : t_stop
  task t_sync;
    repeat (40) begin
      sync_in <= ~sync_in;
      repeat (6) @(posedge aclk);
    end
    chk(forced_continuous, 1'b1);
    repeat (200) @(posedge aclk);
    chk(forced_continuous, 1'b0);
  endtask : t_sync
  task t_regs;
    axr(buck_supervisor_pkg::CTRL_OFFSET);
    chk(rd[15:0], buck_supervisor_pkg::CTRL_RESET);
    axw(buck_supervisor_pkg::CTRL_OFFSET, 32'h00000bb8, buck_supervisor_pkg::RESP_OKAY);
    axr(buck_supervisor_pkg::CTRL_OFFSET);
    chk(rd[15:0], 16'h0bb8);
    axw(8'h10, 32'h00000001, buck_supervisor_pkg::RESP_DECERR);
    axr(8'h10);
    chk(rr, buck_supervisor_pkg::RESP_DECERR);
    {output_sense_at_supply, channel_enable} <= 16'h8301;
    repeat (2) @(posedge aclk);
    axr(buck_supervisor_pkg::GROUP_OFFSET);
    chk({rd[15:8], rd[7]}, 9'h104);
  endtask : t_regs
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    close_out;
  end
  initial begin
    {aresetn, clk_en, mode_pin, bias_low_supply_lockout, temp_hot, temp_cool} = 6'h10;
    {temp_out_tied_bias, freq_set_resistor_tied_bias, sync_in, s_axi_wstrb} = 7'h2f;
    {channel_enable, output_sense_at_supply, above_rise, above_hold, above_excess} = '0;
    {above_excess_clear, channel_low_supply_lockout, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {n_errors, tests_run} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_seq;
    t_sum;
    t_stop;
    t_sync;
    t_regs;
    close_out;
  end
endmodule : tb_octal_buck_supervisor
